// >>> logic/pms_sequencer.sv
// Power mode sequencer top: modes, regulator enables, serial gate, APB registers
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
module pms_sequencer #(
	parameter int WAKE_CYCLES = pms_pkg::WAKE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic regulator_control_pin,
	input wire logic active_low_reset_pin,
	input pms_pkg::pms_serial_t serial_in,
	output pms_pkg::pms_serial_t serial_out,
	output logic low_rail_regulator_en,
	output logic high_rail_regulator_en,
	output logic serial_accept,
	output logic standby_mode
);

	pms_pkg::pms_mode_t mode_q, mode_d;
	logic standby_d, standby_q;
	logic pin_prev_q;
	logic pin_rise;
	logic wake_done;
	logic accept_d;
	logic accept_q;
	logic low_en_d, high_en_d;
	logic low_en_q, high_en_q;
	logic [1:0] hold_q, hold_d;
	logic hold_low, hold_high;
	logic [pms_pkg::DROP_W-1:0] drop_cnt;
	logic apb_access, apb_done;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic [31:0] status_word;

	assign hold_low = hold_q[pms_pkg::HOLD_LOW_BIT];
	assign hold_high = hold_q[pms_pkg::HOLD_HIGH_BIT];
	assign pin_rise = regulator_control_pin && !pin_prev_q;
	// Standby flag is registered so the pin leaves a flop, not a decoder
	assign standby_d = (mode_d == pms_pkg::PMS_STANDBY);

	// Mode transitions; the pin is the only way out of OFF and Standby
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			pms_pkg::PMS_OFF: begin
				if (regulator_control_pin) begin
					mode_d = pms_pkg::PMS_NORMAL;
				end
			end
			pms_pkg::PMS_NORMAL: begin
				if (!regulator_control_pin) begin
					if (hold_high) begin
						mode_d = pms_pkg::PMS_STANDBY;
					end else begin
						mode_d = pms_pkg::PMS_OFF;
					end
				end
			end
			pms_pkg::PMS_STANDBY: begin
				// Only a fresh rise leaves; there is no path to OFF from here
				if (pin_rise) begin
					mode_d = pms_pkg::PMS_NORMAL;
				end
			end
			default: begin
				mode_d = pms_pkg::PMS_OFF;
			end
		endcase
	end

	// Regulator enables: the pin overrides the hold bits
	always_comb begin
		low_en_d = regulator_control_pin;
		high_en_d = regulator_control_pin;
		if (mode_d == pms_pkg::PMS_STANDBY) begin
			low_en_d = low_en_d || hold_low;
			high_en_d = high_en_d || hold_high;
		end
	end

	// Accept only in Normal, pin high, reset pin high and delay expired
	always_comb begin
		accept_d = (mode_q == pms_pkg::PMS_NORMAL)
			&& regulator_control_pin
			&& active_low_reset_pin
			&& wake_done;
	end

	// Mode, pin history, enables and accept flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= pms_pkg::PMS_OFF;
			pin_prev_q <= 1'b0;
			low_en_q <= 1'b0;
			high_en_q <= 1'b0;
			accept_q <= 1'b0;
			standby_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			pin_prev_q <= regulator_control_pin;
			low_en_q <= low_en_d;
			high_en_q <= high_en_d;
			accept_q <= accept_d;
			standby_q <= standby_d;
		end
	end

	// Delay restarts on every rise and is cancelled while the pin is low
	pms_wake_timer u_wake (
		.pclk(pclk),
		.presetn(presetn),
		.limit(pms_pkg::WAKE_CNT_W'(WAKE_CYCLES)),
		.start(pin_rise),
		.clear(!regulator_control_pin),
		.done_q(wake_done)
	);

	// Traffic outside the accept window is dropped and counted
	pms_serial_gate u_gate (
		.pclk(pclk),
		.presetn(presetn),
		.accept(accept_d),
		.word_in(serial_in),
		.word_q(serial_out),
		.drop_q(drop_cnt)
	);

	// APB access completes one cycle into the access phase
	assign apb_access = psel && penable;
	assign apb_done = apb_access && pready_q;

	always_comb begin
		status_word = '0;
		status_word[pms_pkg::ST_STANDBY_BIT] = (mode_q == pms_pkg::PMS_STANDBY);
		status_word[pms_pkg::ST_NORMAL_BIT] = (mode_q == pms_pkg::PMS_NORMAL);
		status_word[pms_pkg::ST_ACCEPT_BIT] = accept_q;
		status_word[pms_pkg::ST_LOW_EN_BIT] = low_en_q;
		status_word[pms_pkg::ST_HIGH_EN_BIT] = high_en_q;
		status_word[pms_pkg::ST_DROP_LSB +: pms_pkg::DROP_W] = drop_cnt;
	end

	// Read data, ready and error; unmapped offsets answer with an error
	always_comb begin
		pready_d = apb_access && !pready_q;
		pslverr_d = 1'b0;
		prdata_d = '0;
		if (apb_access && !pready_q) begin
			if (paddr == pms_pkg::HOLD_ADDR) begin
				prdata_d = {30'h0, hold_q};
			end else if (paddr == pms_pkg::STATUS_ADDR && !pwrite) begin
				prdata_d = status_word;
			end else begin
				pslverr_d = 1'b1;
			end
		end
	end

	// Hold bits; a low reset pin wipes the setup even over a write
	always_comb begin
		hold_d = hold_q;
		if (apb_done && pwrite && !pslverr_q && paddr == pms_pkg::HOLD_ADDR && pstrb[0]) begin
			hold_d = pwdata[1:0];
		end
		if (!active_low_reset_pin) begin
			hold_d = pms_pkg::HOLD_RESET;
		end
	end

	// Bus answer and hold registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
			hold_q <= pms_pkg::HOLD_RESET;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
			hold_q <= hold_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign low_rail_regulator_en = low_en_q;
	assign high_rail_regulator_en = high_en_q;
	assign serial_accept = accept_q;
	assign standby_mode = standby_q;

	// Checks on the sequencing; helper counts cycles since the last rise
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Cycles since the last rise; saturates so a long Normal stretch never wraps
	logic [pms_pkg::WAKE_CNT_W-1:0] since_rise_q, since_rise_d;
	always_comb begin
		since_rise_d = since_rise_q;
		if (pin_rise) begin
			since_rise_d = '0;
		end else if (since_rise_q != '1) begin
			since_rise_d = since_rise_q + 1'b1;
		end
	end

	// Helper register for the checks only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_rise_q <= '0;
		end else begin
			since_rise_q <= since_rise_d;
		end
	end

	a_off_stays_off: assert property (
		mode_q == pms_pkg::PMS_OFF && !regulator_control_pin |=> mode_q == pms_pkg::PMS_OFF
	) else $error("OFF left without control pin high");

	a_standby_entry: assert property (
		mode_q == pms_pkg::PMS_NORMAL && !regulator_control_pin && hold_high
		|=> mode_q == pms_pkg::PMS_STANDBY
	) else $error("Standby not entered with high hold set");

	a_standby_no_off: assert property (
		mode_q == pms_pkg::PMS_STANDBY |=> mode_q != pms_pkg::PMS_OFF
	) else $error("Direct Standby to OFF move");

	a_standby_wake: assert property (
		mode_q == pms_pkg::PMS_STANDBY && pin_rise |=> mode_q == pms_pkg::PMS_NORMAL
	) else $error("Rising pin did not leave Standby");

	a_pin_rails_on: assert property (
		regulator_control_pin |=> low_rail_regulator_en && high_rail_regulator_en
	) else $error("Regulator off while control pin high");

	a_reset_rejects: assert property (
		!active_low_reset_pin |=> !serial_out.valid
	) else $error("Serial word passed while reset pin low");

	a_standby_rejects: assert property (
		mode_q == pms_pkg::PMS_STANDBY |=> !serial_out.valid && !serial_accept
	) else $error("Serial traffic accepted in Standby");

	a_pin_low_rejects: assert property (
		!regulator_control_pin && (!hold_low || !hold_high) |=> !serial_out.valid
	) else $error("Serial word passed with pin low and hold clear");

	a_wake_delay: assert property (
		accept_d |-> since_rise_q >= pms_pkg::WAKE_CNT_W'(WAKE_CYCLES)
	) else $error("Serial accepted before wake delay");

	a_early_closed: assert property (
		pin_rise |-> !accept_d [*8]
	) else $error("Accept open right after rise");

	a_hold_cleared: assert property (
		!active_low_reset_pin |=> hold_q == pms_pkg::HOLD_RESET
	) else $error("Hold bits survived reset pin");

	// A rail may stay up with the pin low only through its own hold bit
	a_low_rail_off: assert property (
		!regulator_control_pin && !hold_low |=> !low_rail_regulator_en
	) else $error("Low rail on with pin low and low hold clear");

	a_high_rail_off: assert property (
		!regulator_control_pin && !hold_high |=> !high_rail_regulator_en
	) else $error("High rail on with pin low and high hold clear");

	a_off_entry: assert property (
		mode_q == pms_pkg::PMS_NORMAL && !regulator_control_pin && !hold_high
		|=> mode_q == pms_pkg::PMS_OFF
	) else $error("Pin fall without high hold did not reach OFF");

	a_pin_low_closed: assert property (
		!regulator_control_pin |=> !serial_accept
	) else $error("Accept flag high with control pin low");

	a_standby_flag: assert property (
		standby_mode |-> !serial_accept
	) else $error("Accept flag high in Standby");

	c_enter_standby: cover property (
		mode_q == pms_pkg::PMS_NORMAL ##1 mode_q == pms_pkg::PMS_STANDBY
	);
	c_leave_standby: cover property (
		mode_q == pms_pkg::PMS_STANDBY ##1 mode_q == pms_pkg::PMS_NORMAL
	);
	c_word_passed: cover property (serial_out.valid);
	c_reset_pin_drop: cover property (!active_low_reset_pin && serial_in.valid);
	c_enter_off: cover property (
		mode_q == pms_pkg::PMS_NORMAL ##1 mode_q == pms_pkg::PMS_OFF
	);

endmodule

// >>> pkg/pms_pkg.sv
// Constants, types and register layout of the power mode sequencer
package pms_pkg;

	// Clock and wake-up delay
	localparam int CLK_PERIOD_NS = 8;
	localparam int WAKE_MS = 5;
	localparam int WAKE_CYCLES = (WAKE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_CNT_W = 20;

	// Register indices; byte address is four times the index
	localparam logic [7:0] HOLD_IDX = 8'h02;
	localparam logic [7:0] STATUS_IDX = 8'h40;
	localparam logic [11:0] HOLD_ADDR = {2'h0, HOLD_IDX, 2'h0};
	localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};

	// Hold register fields and reset value
	localparam int HOLD_HIGH_BIT = 0;
	localparam int HOLD_LOW_BIT = 1;
	localparam logic [1:0] HOLD_RESET = 2'h0;

	// Status register fields
	localparam int ST_STANDBY_BIT = 0;
	localparam int ST_NORMAL_BIT = 1;
	localparam int ST_ACCEPT_BIT = 2;
	localparam int ST_LOW_EN_BIT = 3;
	localparam int ST_HIGH_EN_BIT = 4;
	localparam int ST_DROP_LSB = 8;
	localparam int DROP_W = 8;

	typedef enum logic [1:0] {
		PMS_OFF,
		PMS_NORMAL,
		PMS_STANDBY
	} pms_mode_t;

	// One serial word with its strobe
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} pms_serial_t;

	localparam pms_serial_t SERIAL_IDLE = '{valid: 1'b0, data: 8'h00};

endpackage

// >>> logic/pms_wake_timer.sv
// Wake-up delay counter started by a rising control pin
`timescale 1ns/1ns
module pms_wake_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [pms_pkg::WAKE_CNT_W-1:0] limit,
	input wire logic start,
	input wire logic clear,
	output logic done_q
);

	logic [pms_pkg::WAKE_CNT_W-1:0] cnt_q, cnt_d;
	logic run_q, run_d;
	logic done_d;

	// Clear wins so a pin that drops mid-count never leaves a stale done
	always_comb begin
		cnt_d = cnt_q;
		run_d = run_q;
		done_d = done_q;
		if (clear) begin
			cnt_d = '0;
			run_d = 1'b0;
			done_d = 1'b0;
		end else if (start) begin
			cnt_d = limit - 1'b1;
			run_d = 1'b1;
			done_d = 1'b0;
		end else if (run_q) begin
			if (cnt_q == '0) begin
				run_d = 1'b0;
				done_d = 1'b1;
			end else begin
				cnt_d = cnt_q - 1'b1;
			end
		end
	end

	// Counter registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			done_q <= done_d;
		end
	end

endmodule

// >>> logic/pms_serial_gate.sv
// Passes serial words only while accepting, counts the dropped ones
`timescale 1ns/1ns
module pms_serial_gate (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic accept,
	input pms_pkg::pms_serial_t word_in,
	output pms_pkg::pms_serial_t word_q,
	output logic [pms_pkg::DROP_W-1:0] drop_q
);

	pms_pkg::pms_serial_t word_d;
	logic [pms_pkg::DROP_W-1:0] drop_d;

	// Dropped count saturates so software never sees a wrap to zero
	always_comb begin
		word_d = pms_pkg::SERIAL_IDLE;
		drop_d = drop_q;
		if (word_in.valid && accept) begin
			word_d = word_in;
		end else if (word_in.valid && drop_q != '1) begin
			drop_d = drop_q + 1'b1;
		end
	end

	// Output word and counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_q <= pms_pkg::SERIAL_IDLE;
			drop_q <= '0;
		end else begin
			word_q <= word_d;
			drop_q <= drop_d;
		end
	end

endmodule

// >>> sim/pms_host_model.sv
// Host model driving the control pin and the active-low reset pin
`timescale 1ns/1ns
module pms_host_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic on_req,
	input wire logic rst_req,
	input wire logic standby_mode,
	output logic regulator_control_pin,
	output logic active_low_reset_pin
);
	// Reset is withheld while off or in Standby; a held request spans several clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regulator_control_pin <= 1'b0;
			active_low_reset_pin <= 1'b1;
		end else begin
			regulator_control_pin <= on_req;
			active_low_reset_pin <= !(rst_req && regulator_control_pin && !standby_mode);
		end
	end
	// General inputs and port pins are never driven by this host
endmodule

// >>> sim/power_mode_sequencer_tb.sv
// Self-checking testbench of the power mode sequencer
`timescale 1ns/1ns
module power_mode_sequencer_tb;
	localparam int WAKE = 20;
	// Hold value and the high en, low en, standby bits after the pin falls
	typedef struct packed {
		logic [1:0] hold;
		logic [2:0] st;
	} pms_row_t;
	pms_row_t rows [4] = '{'{2'h0, 3'h0}, '{2'h1, 3'h5}, '{2'h2, 3'h0}, '{2'h3, 3'h7}};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic ctl, rstn, low_en, high_en, acc, stby, on_req, rst_req;
	pms_pkg::pms_serial_t serial_in, serial_out, sv;
	logic [7:0] d;
	int miscompares, comparisons, cycles, n;

	pms_host_model host (.pclk(pclk), .presetn(presetn), .on_req(on_req), .rst_req(rst_req),
		.standby_mode(stby), .regulator_control_pin(ctl), .active_low_reset_pin(rstn));
	pms_sequencer #(.WAKE_CYCLES(WAKE)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .regulator_control_pin(ctl),
		.active_low_reset_pin(rstn), .serial_in(serial_in), .serial_out(serial_out),
		.low_rail_regulator_en(low_en), .high_rail_regulator_en(high_en),
		.serial_accept(acc), .standby_mode(stby));

	always #4 pclk = ~pclk;

	// Cut a hang short; the whole run needs well under this
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Status word with the running drop count
	function automatic logic [31:0] st(input logic [7:0] v);
		return {16'h0, d, v};
	endfunction

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Sampled at the rising edge, before the design updates its flops
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic send(input logic [7:0] b);
		@(posedge pclk);
		serial_in <= '{valid: 1'b1, data: b};
		@(posedge pclk);
		serial_in <= pms_pkg::SERIAL_IDLE;
		@(negedge pclk);
		sv = serial_out;
	endtask

	// Raise the control pin and count cycles until traffic is accepted
	task automatic wake();
		n = 0;
		on_req <= 1'b1;
		do begin
			@(negedge pclk);
			n++;
		end while (acc !== 1'b1);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		serial_in = pms_pkg::SERIAL_IDLE;
		on_req = 1'b0;
		rst_req = 1'b0;
		d = 8'h00;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, pms_pkg::STATUS_ADDR, 32'h0);
		chk("status reset", rd, 32'h0);
		apb(1'b0, pms_pkg::HOLD_ADDR, 32'h0);
		chk("hold reset", rd, 32'h0);
		apb(1'b0, 12'h0FC, 32'h0);
		chk("unmapped err", {31'h0, er}, 32'h1);
		apb(1'b1, pms_pkg::STATUS_ADDR, 32'h1F);
		chk("status write err", {31'h0, er}, 32'h1);
		// Register writes and serial traffic alone never leave OFF
		apb(1'b1, pms_pkg::HOLD_ADDR, 32'h3);
		send(8'h11);
		chk("off serial", {31'h0, sv.valid}, 32'h0);
		d++;
		apb(1'b0, pms_pkg::STATUS_ADDR, 32'h0);
		chk("status off", rd, st(8'h00));
		foreach (rows[i]) begin
			apb(1'b1, pms_pkg::HOLD_ADDR, {30'h0, rows[i].hold});
			@(posedge pclk);
			wake();
			chk("wake cycles", {31'h0, n >= WAKE + 2 && n <= WAKE + 6}, 32'h1);
			apb(1'b0, pms_pkg::STATUS_ADDR, 32'h0);
			chk("status normal", rd, st(8'h1E));
			send(8'hC3);
			chk("serial pass", {23'h0, sv}, {23'h0, 1'b1, 8'hC3});
			@(posedge pclk);
			on_req <= 1'b0;
			repeat (4) @(posedge pclk);
			apb(1'b0, pms_pkg::STATUS_ADDR, 32'h0);
			chk("status low", rd, st({3'h0, rows[i].st[2:1], 2'h0, rows[i].st[0]}));
			chk("pins low", {29'h0, high_en, low_en, stby}, {29'h0, rows[i].st});
			send(8'h3C);
			chk("low serial", {31'h0, sv.valid}, 32'h0);
			d++;
		end
		// Standby left by a rising pin, delay restarts
		@(posedge pclk);
		on_req <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, pms_pkg::STATUS_ADDR, 32'h0);
		chk("standby exit", rd, st(8'h1A));
		@(posedge pclk);
		wake();
		// Reset pin held low blocks traffic and clears the hold bits
		@(posedge pclk);
		rst_req <= 1'b1;
		repeat (3) @(posedge pclk);
		send(8'h77);
		chk("reset serial", {31'h0, sv.valid}, 32'h0);
		d++;
		@(posedge pclk);
		rst_req <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(1'b0, pms_pkg::HOLD_ADDR, 32'h0);
		chk("hold cleared", rd, 32'h0);
		apb(1'b0, pms_pkg::STATUS_ADDR, 32'h0);
		chk("drop count", {24'h0, rd[15:8]}, {24'h0, d});
		// Mid-run reset: back to OFF with an empty count, then the delay runs again
		on_req <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("pins after reset", {28'h0, high_en, low_en, acc, stby}, 32'h0);
		d = 8'h00;
		apb(1'b0, pms_pkg::STATUS_ADDR, 32'h0);
		chk("status after reset", rd, st(8'h00));
		@(posedge pclk);
		wake();
		chk("wake after reset", {31'h0, n >= WAKE + 2 && n <= WAKE + 6}, 32'h1);
		wrap_up();
	end
endmodule
